// ---- rtl/ccs_regs.svh ----
// Purpose: Offsets, field positions, reset values and timing for the charger register slice
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

`define CCS_ADDR_SAG        8'h05
`define CCS_ADDR_TMR        8'h06

`define CCS_SAG_MINSYS_BIT  7
`define CCS_SAG_LOOP_BIT    6
`define CCS_SAG_REDCHG_BIT  5
`define CCS_SAG_FORCE_BIT   4
`define CCS_SAG_DIS_BIT     3
`define CCS_SAG_CODE_HI     2
`define CCS_SAG_CODE_LO     0

`define CCS_TMR_HALF_BIT    7
`define CCS_TMR_LIM_HI      6
`define CCS_TMR_LIM_LO      5
`define CCS_TMR_OTG_BIT     4
`define CCS_TMR_THERM_EN_BIT 3
`define CCS_TMR_FLT_HI      2
`define CCS_TMR_FLT_LO      1
`define CCS_TMR_BASE_BIT    0

`define CCS_SAG_RW_MASK     8'h37
`define CCS_TMR_RW_MASK     8'hF9
`define CCS_SAG_RESET       8'h00
`define CCS_TMR_RESET       8'h98

`define CCS_DET_TIME_US     10
`define CCS_CLK_MHZ         25
`define CCS_DET_CYCLES      (`CCS_DET_TIME_US * `CCS_CLK_MHZ)

`endif

// ---- rtl/ccs_pkg.sv ----
// Purpose: Types for the charger register slice
// Assumes: Constants live in ccs_regs.svh
// Notes:   Nothing is imported
package ccs_pkg;
  typedef enum logic [1:0] {
    CCS_LIM_SHORT,
    CCS_LIM_6H,
    CCS_LIM_9H,
    CCS_LIM_OFF
  } ccs_limit_t;

  typedef enum logic [1:0] {
    CCS_TS_NORMAL,
    CCS_TS_SUSPEND,
    CCS_TS_COOL,
    CCS_TS_WARM
  } ccs_ts_fault_t;

  typedef enum logic {
    CCS_DET_IDLE,
    CCS_DET_BUSY
  } ccs_det_state_t;
endpackage

// ---- rtl/ccs_sync.sv ----
// Purpose: Two-flop synchroniser for a bus of asynchronous levels
// Assumes: Inputs are quasi-static levels
// Notes:   First stage is read only by the second
`timescale 1ns/10ps
module ccs_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ---- rtl/ccs_regs_top.sv ----
// Purpose: Input-sag/status and safety-timer/thermistor registers of a charger
// Assumes: Register port decoded from the serial interface; status levels are asynchronous
// Notes:   Status levels pass a two-flop synchroniser before the read mux
// Operation
// - Bit 7 of register 05 reads 1 while minimum system mode is active.
// - Bit 6 of register 05 reads 1 while the input-sag loop limits.
// - Bit 5 reduced charge select, default 0; 1 selects fixed 300 mA.
// - Host writes bit 4 to force port detection; reads 0 when done.
// - Bit 3 mirrors the chip disable pin level.
// - Bits 2:0 input-sag code, default 0, 2 percent base steps.
// - Register 06 bit 0 selects 4.2 V or 10.1 V base, default 0.
// - Bit 7 half-speed timer enable, default 1.
// - Bits 6:5 safety limit code, default 00; 11 disables timers.
// - Bit 4 boost current cap select, default 1.
// - Bit 3 thermistor enable, default 1.
// - Bits 2:1 read live thermistor fault code.
// - Register 05 at address 05, reset pattern xx00 x000.
`timescale 1ns/10ps
`include "ccs_regs.svh"
module ccs_regs_top #(
  parameter int DET_CYCLES = `CCS_DET_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       min_system_mode_in,
  input  wire logic       input_sag_loop_in,
  input  wire logic       chip_disable_pin,
  input  wire logic [1:0] thermistor_fault_in,
  input  wire logic       port_detect_done,
  output logic            reduced_charge_select,
  output logic            force_port_detection,
  output logic      [2:0] input_sag_code,
  output logic            input_sag_base_select,
  output logic            timer_halfspeed_enable,
  output ccs_pkg::ccs_limit_t safety_limit,
  output logic            otg_current_cap_select,
  output logic            thermistor_enable
);
  logic [4:0] status_sync;
  logic [7:0] sag_reg;
  logic [7:0] tmr_reg;
  logic [7:0] next_sag_reg;
  logic [7:0] next_tmr_reg;
  logic [7:0] next_rdata;
  logic       force_write;
  logic [15:0] det_count;
  logic [15:0] next_det_count;
  ccs_pkg::ccs_det_state_t det_state;
  ccs_pkg::ccs_det_state_t next_det_state;

  ccs_sync #(.WIDTH(5)) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in ({min_system_mode_in, input_sag_loop_in, chip_disable_pin,
                thermistor_fault_in}),
    .sync_out (status_sync)
  );

  function automatic logic [7:0] merge_rw(input logic [7:0] old_v, input logic [7:0] new_v,
                                           input logic [7:0] mask);
    merge_rw = (old_v & ~mask) | (new_v & mask);
  endfunction

  // Register storage and port-detection sequencing
  always_comb begin
    next_sag_reg   = sag_reg;
    next_tmr_reg   = tmr_reg;
    next_det_state = det_state;
    next_det_count = det_count;
    force_write    = reg_write && reg_addr == `CCS_ADDR_SAG && reg_wdata[`CCS_SAG_FORCE_BIT];
    if (reg_write && reg_addr == `CCS_ADDR_SAG) begin
      next_sag_reg = merge_rw(sag_reg, reg_wdata, `CCS_SAG_RW_MASK);
    end
    if (reg_write && reg_addr == `CCS_ADDR_TMR) begin
      next_tmr_reg = merge_rw(tmr_reg, reg_wdata, `CCS_TMR_RW_MASK);
    end
    unique case (det_state)
      ccs_pkg::CCS_DET_IDLE: begin
        if (next_sag_reg[`CCS_SAG_FORCE_BIT]) begin
          next_det_state = ccs_pkg::CCS_DET_BUSY;
          next_det_count = 16'h0000;
        end
      end
      ccs_pkg::CCS_DET_BUSY: begin
        next_det_count = det_count + 16'h0001;
        if (port_detect_done || det_count == 16'(DET_CYCLES - 1)) begin
          if (force_write) begin
            // A fresh request in the finishing cycle wins and restarts detection
            next_det_count = 16'h0000;
          end else begin
            next_det_state = ccs_pkg::CCS_DET_IDLE;
            next_sag_reg[`CCS_SAG_FORCE_BIT] = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sag_reg   <= `CCS_SAG_RESET;
      tmr_reg   <= `CCS_TMR_RESET;
      det_state <= ccs_pkg::CCS_DET_IDLE;
      det_count <= 16'h0000;
    end else begin
      sag_reg   <= next_sag_reg;
      tmr_reg   <= next_tmr_reg;
      det_state <= next_det_state;
      det_count <= next_det_count;
    end
  end

  // Read data with live status in read-only positions
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_read) begin
      if (reg_addr == `CCS_ADDR_SAG) begin
        next_rdata = sag_reg;
        next_rdata[`CCS_SAG_MINSYS_BIT] = status_sync[4];
        next_rdata[`CCS_SAG_LOOP_BIT]   = status_sync[3];
        next_rdata[`CCS_SAG_DIS_BIT]    = status_sync[2];
      end else if (reg_addr == `CCS_ADDR_TMR) begin
        next_rdata = tmr_reg;
        next_rdata[`CCS_TMR_FLT_HI:`CCS_TMR_FLT_LO] = status_sync[1:0];
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Control outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reduced_charge_select  <= 1'b0;
      force_port_detection   <= 1'b0;
      input_sag_code         <= 3'h0;
      input_sag_base_select  <= 1'b0;
      timer_halfspeed_enable <= 1'b1;
      safety_limit           <= ccs_pkg::CCS_LIM_SHORT;
      otg_current_cap_select <= 1'b1;
      thermistor_enable      <= 1'b1;
    end else begin
      reduced_charge_select  <= next_sag_reg[`CCS_SAG_REDCHG_BIT];
      force_port_detection   <= next_sag_reg[`CCS_SAG_FORCE_BIT];
      input_sag_code         <= next_sag_reg[`CCS_SAG_CODE_HI:`CCS_SAG_CODE_LO];
      input_sag_base_select  <= next_tmr_reg[`CCS_TMR_BASE_BIT];
      timer_halfspeed_enable <= next_tmr_reg[`CCS_TMR_HALF_BIT];
      safety_limit           <= ccs_pkg::ccs_limit_t'(
                                next_tmr_reg[`CCS_TMR_LIM_HI:`CCS_TMR_LIM_LO]);
      otg_current_cap_select <= next_tmr_reg[`CCS_TMR_OTG_BIT];
      thermistor_enable      <= next_tmr_reg[`CCS_TMR_THERM_EN_BIT];
    end
  end

  // Checks
  property p_ro_live;
    @(posedge clock) disable iff (!rst_n)
      (reg_read && reg_addr == `CCS_ADDR_SAG) |=> reg_rdata[7] == $past(status_sync[4]);
  endproperty
  minsys_flag_live_a: assert property (p_ro_live) else $error("min system flag wrong");
  loop_flag_live_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_read && reg_addr == `CCS_ADDR_SAG) |=> reg_rdata[6] == $past(status_sync[3]))
    else $error("sag loop flag wrong");
  redchg_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == `CCS_ADDR_SAG) |=> reduced_charge_select == $past(reg_wdata[5]))
    else $error("reduced charge not written");
  force_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    (det_state == ccs_pkg::CCS_DET_IDLE && force_write) |=> force_port_detection)
    else $error("force detect not set");
  force_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (det_state == ccs_pkg::CCS_DET_BUSY && port_detect_done && !force_write)
    |=> !force_port_detection)
    else $error("force detect not cleared");
  det_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
    det_state == ccs_pkg::CCS_DET_BUSY |-> det_count < 16'(DET_CYCLES))
    else $error("detection count overrun");
  disable_pin_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_read && reg_addr == `CCS_ADDR_SAG) |=> reg_rdata[3] == $past(status_sync[2]))
    else $error("disable pin mirror wrong");
  sag_code_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == `CCS_ADDR_SAG) |=> input_sag_code == $past(reg_wdata[2:0]))
    else $error("sag code not written");
  base_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == `CCS_ADDR_TMR) |=> input_sag_base_select == $past(reg_wdata[0]))
    else $error("base select not written");
  halfspeed_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == `CCS_ADDR_TMR)
    |=> timer_halfspeed_enable == $past(reg_wdata[`CCS_TMR_HALF_BIT]))
    else $error("half speed enable not written");
  limit_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == `CCS_ADDR_TMR) |=> safety_limit == $past(reg_wdata[6:5]))
    else $error("safety limit not written");
  otg_cap_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == `CCS_ADDR_TMR)
    |=> otg_current_cap_select == $past(reg_wdata[`CCS_TMR_OTG_BIT]))
    else $error("boost cap select not written");
  therm_en_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == `CCS_ADDR_TMR)
    |=> thermistor_enable == $past(reg_wdata[`CCS_TMR_THERM_EN_BIT]))
    else $error("thermistor enable not written");
  fault_live_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_read && reg_addr == `CCS_ADDR_TMR) |=> reg_rdata[2:1] == $past(status_sync[1:0]))
    else $error("thermistor fault not live");
  unmapped_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_read && reg_addr != `CCS_ADDR_SAG && reg_addr != `CCS_ADDR_TMR)
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  ro_kept_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == `CCS_ADDR_TMR) |=> tmr_reg[2:1] == 2'b00)
    else $error("read-only bits stored");
  sag_ro_kept_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_write && reg_addr == `CCS_ADDR_SAG) |=> sag_reg[7:6] == 2'b00 && !sag_reg[3])
    else $error("status bits stored");

  detect_cov: cover property (@(posedge clock) disable iff (!rst_n)
    det_state == ccs_pkg::CCS_DET_BUSY ##1 det_state == ccs_pkg::CCS_DET_IDLE);
  sag_read_cov: cover property (@(posedge clock) disable iff (!rst_n)
    reg_read && reg_addr == `CCS_ADDR_SAG && status_sync[4]);
  tmr_write_cov: cover property (@(posedge clock) disable iff (!rst_n)
    reg_write && reg_addr == `CCS_ADDR_TMR && reg_wdata[6:5] == 2'b11);
  restart_cov: cover property (@(posedge clock) disable iff (!rst_n)
    det_state == ccs_pkg::CCS_DET_BUSY && port_detect_done && force_write);
endmodule

// ---- bench/ccs_host.sv ----
// Purpose: Host model issuing register accesses to the charger slice
// Assumes: Strobes change at the falling edge, one access at a time
// Notes:   Released write data shows the inverse of the last byte
`timescale 1ns/10ps
module ccs_host (
  input  wire logic       clock,
  output logic      [7:0] reg_addr,
  output logic            reg_write,
  output logic      [7:0] reg_wdata,
  output logic            reg_read,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    reg_read = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    d = reg_rdata;
  endtask
endmodule

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the charger register slice
// Assumes: Host model drives the register port
// Notes:   Short detection timeout keeps the run small
`timescale 1ns/10ps
module tb;
  localparam int DET = 4;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, s05, s06, rv;
  logic reg_write, reg_read;
  logic min_system_mode_in = 1'b0;
  logic input_sag_loop_in = 1'b0;
  logic chip_disable_pin = 1'b0;
  logic [1:0] thermistor_fault_in = 2'b00;
  logic port_detect_done = 1'b0;
  logic reduced_charge_select, force_port_detection, input_sag_base_select;
  logic timer_halfspeed_enable, otg_current_cap_select, thermistor_enable;
  logic [2:0] input_sag_code;
  ccs_pkg::ccs_limit_t safety_limit;
  int failures = 0;
  int total_checks = 0;
  int det_wait;
  integer seed = 9;
  always #20 clock = ~clock;
  ccs_regs_top #(.DET_CYCLES(DET)) uut (.clock, .rst_n, .reg_addr, .reg_write, .reg_wdata,
    .reg_read, .reg_rdata, .min_system_mode_in, .input_sag_loop_in, .chip_disable_pin,
    .thermistor_fault_in, .port_detect_done, .reduced_charge_select, .force_port_detection,
    .input_sag_code, .input_sag_base_select, .timer_halfspeed_enable, .safety_limit,
    .otg_current_cap_select, .thermistor_enable);
  ccs_host u_host (.clock, .reg_addr, .reg_write, .reg_wdata, .reg_read, .reg_rdata);
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  function automatic logic [7:0] exp05(input logic [7:0] st);
    return {min_system_mode_in, input_sag_loop_in, st[5:4], chip_disable_pin, st[2:0]};
  endfunction
  function automatic logic [7:0] exp06(input logic [7:0] st);
    return {st[7:3], thermistor_fault_in, st[0]};
  endfunction
  task automatic check_all();
    u_host.rd(8'h05, rv);
    chk(rv, exp05(s05), "reg05 read");
    u_host.rd(8'h06, rv);
    chk(rv, exp06(s06), "reg06 read");
    chk({timer_halfspeed_enable, safety_limit, otg_current_cap_select, thermistor_enable,
         2'b00, input_sag_base_select}, s06 & 8'hF9, "reg06 outputs");
    chk({2'b00, reduced_charge_select, force_port_detection, 1'b0, input_sag_code},
        s05 & 8'h37, "reg05 outputs");
  endtask
  task automatic wait_clear(input int bound, output int n);
    n = 0;
    while (force_port_detection !== 1'b0 && n < bound) begin
      @(negedge clock);
      n++;
    end
    chk({7'h00, force_port_detection}, 8'h00, "detect clear");
    if (force_port_detection !== 1'b0) begin
      final_report();
    end
  endtask
  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    s05 = 8'h00;
    s06 = 8'h98;
    check_all();
    $display("test reset values done");
    for (int i = 0; i < 30; i++) begin
      @(negedge clock);
      {min_system_mode_in, input_sag_loop_in, chip_disable_pin, thermistor_fault_in} =
        5'($random(seed));
      rv = (i == 0) ? 8'hEF : 8'($random(seed));
      u_host.wr(8'h05, rv & 8'hEF);
      s05 = rv & 8'h27;
      rv = (i == 0) ? 8'hFF : 8'($random(seed));
      u_host.wr(8'h06, rv);
      s06 = rv;
      check_all();
    end
    $display("test random access done");
    u_host.wr(8'h07, 8'hFF);
    u_host.rd(8'h07, rv);
    chk(rv, 8'h00, "unmapped read");
    check_all();
    $display("test unmapped done");
    u_host.wr(8'h05, 8'h10);
    s05 = 8'h10;
    chk({7'h00, force_port_detection}, 8'h01, "detect set");
    port_detect_done = 1'b1;
    @(negedge clock);
    port_detect_done = 1'b0;
    wait_clear(6, det_wait);
    chk(8'(det_wait), 8'h00, "detect ends on done");
    s05 = 8'h00;
    check_all();
    u_host.wr(8'h05, 8'h10);
    fork
      u_host.wr(8'h05, 8'h10);
      begin
        @(negedge clock);
        port_detect_done = 1'b1;
        @(negedge clock);
        port_detect_done = 1'b0;
      end
    join
    wait_clear(DET + 6, det_wait);
    chk(8'(det_wait), 8'(DET), "detect restart timeout");
    $display("test detection done");
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    s06 = 8'h98;
    check_all();
    $display("test mid-run reset done");
    final_report();
  end
endmodule
